// ===== snv_top.sv
`timescale 1ns/1ns
// Function
// [R01] modes 0 and 3: rise samples, fall drives
// [R02] chip select high: output floats, inputs ignored
// [R03] host lowers chip select before opcode
// [R04] hold low floats output, freezes transfer
// [R05] decode the nine eight-bit opcodes
// [R06] host sends only the nine opcodes
// [R07] short opcode at select rise does nothing
// [R08] status holds protect-enable, spare, block-protect
// [R09] bit0 reads zero; status write skips bits1,0
// [R10] set/clear commands drive readable enable latch
// [R11] latch cleared: reset, clear, write end, wake
// [R12] no writes while enable latch clear
// [R13] status read repeats status byte
// [R14] status write shifts eight data bits, stored at the eighth
// [R15] host holds write-protect stable during status write
// [R16] read: sixteen address bits, then byte out
// [R17] further read bytes increment address, wrapping
// [R18] write: byte stored at its eighth bit
// [R19] further write bytes increment address, wrapping
// [R20] fast read skips eight dummy bits
// [R21] block-protect pair selects protected range
// [R22] protected blocks stay; status write gated
// [R23] ident read: 32 bits, last bit held
// [R24] sleep at select rise; wake after recovery
// [R25] all fields shifted most significant first
module snv_top #(
  parameter int unsigned REC_CYCLES = snv_pkg::REC_CYCLES
) (
  // clock and reset
  input  wire logic I_MCLK,
  input  wire logic I_RST_N,
  // serial link
  input  wire logic I_CS_N,
  input  wire logic I_SCK,
  input  wire logic I_SI,
  output logic      O_SO,
  output logic      O_SO_OE,
  // control pins
  input  wire logic I_HOLD_N,
  input  wire logic I_WP_N
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection
  snv_pkg::snv_pins_t  pin_raw;
  snv_pkg::snv_pins_t  pin_s;
  snv_pkg::snv_pins_t  pin_q;
  snv_pkg::snv_state_t state_q;
  logic [4:0]          cnt_q;
  logic [15:0]         sh_q;
  logic [7:0]          cmd_q;
  logic [15:0]         addr_q;
  logic [5:0]          oc_q;
  logic [7:0]          stat_q;
  logic                wel_q;
  logic                wcmd_q;
  logic                sleep_pend_q;
  logic                sleep_q;
  logic                waking_q;
  logic [15:0]         rec_q;
  logic                so_q;
  logic                oe_q;
  logic [7:0]          mem_rd;
  logic                sel;
  logic                run;
  logic                sck_rise;
  logic                sck_fall;
  logic                cs_rise;
  logic                cs_fall;
  logic [7:0]          byte_in;
  logic [15:0]         word_in;
  logic [7:0]          status_rd;
  logic                opc_done;
  logic                mem_we;
  logic                st_we;
  logic                out_state;

  assign pin_raw = {I_CS_N, I_SCK, I_SI, I_HOLD_N, I_WP_N};

  snv_sync #(
    .W   ($bits(snv_pkg::snv_pins_t)),
    .RST (snv_pkg::PINS_IDLE)
  ) u_sync (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_d     (pin_raw),
    .o_q     (pin_s)
  );

  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      pin_q <= snv_pkg::PINS_IDLE;
    else
      pin_q <= pin_s;
  end

  assign sel      = !pin_s.cs_n && !sleep_q;                          // [R02]
  assign run      = sel && pin_s.hold_n;                              // [R04]
  assign sck_rise = run && pin_s.sck && !pin_q.sck;                   // [R01]
  assign sck_fall = run && !pin_s.sck && pin_q.sck;                   // [R01]
  assign cs_rise  = pin_s.cs_n && !pin_q.cs_n;
  assign cs_fall  = !pin_s.cs_n && pin_q.cs_n;
  assign byte_in  = {sh_q[6:0], pin_s.si};                            // [R25]
  assign word_in  = {sh_q[14:0], pin_s.si};                           // [R25]
  assign status_rd = {stat_q[7:2], wel_q, 1'b0};                      // [R09]
  assign opc_done = sck_rise && (state_q == snv_pkg::ST_OPC) && (cnt_q == snv_pkg::BYTE_LAST);
  assign out_state = (state_q == snv_pkg::ST_SRD) || (state_q == snv_pkg::ST_RDATA)
                  || (state_q == snv_pkg::ST_IDRD);

  ////////////////////////////////////////////////////////////////////////////
  // write gating
  function automatic logic prot_hit(input logic [1:0] bp, input logic [15:0] a);
    case (bp)
      snv_pkg::BP_NONE:    prot_hit = 1'b0;
      snv_pkg::BP_QUARTER: prot_hit = (a >= snv_pkg::PROT_QTR_BASE);
      snv_pkg::BP_HALF:    prot_hit = (a >= snv_pkg::PROT_HALF_BASE);
      default:             prot_hit = 1'b1;
    endcase
  endfunction : prot_hit

  // [R12] [R18] [R21] [R22]
  assign mem_we = sck_rise && (state_q == snv_pkg::ST_WDATA) && (cnt_q[2:0] == 3'h7)
               && wel_q && !prot_hit(stat_q[snv_pkg::ST_BP_HI_BIT:snv_pkg::ST_BP_LO_BIT], addr_q);
  // [R12] [R14] [R22]
  assign st_we = sck_rise && (state_q == snv_pkg::ST_SWR) && (cnt_q == snv_pkg::BYTE_LAST)
              && wel_q && !(stat_q[snv_pkg::ST_PROT_EN_BIT] && !pin_s.wp_n);

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state_q <= snv_pkg::ST_OPC;
      cnt_q   <= 5'h00;
    end
    else if (pin_s.cs_n)
    begin
      state_q <= snv_pkg::ST_OPC;                                     // [R07]
      cnt_q   <= 5'h00;
    end
    else if (sleep_q)
    begin
      state_q <= snv_pkg::ST_IGN;
      cnt_q   <= 5'h00;
    end
    else if (sck_rise)
    begin
      cnt_q <= cnt_q + 5'h01;
      case (state_q)
        snv_pkg::ST_OPC:
        begin
          if (cnt_q == snv_pkg::BYTE_LAST)
          begin
            cnt_q <= 5'h00;
            case (byte_in)                                            // [R05]
              snv_pkg::OPC_ST_RD:   state_q <= snv_pkg::ST_SRD;
              snv_pkg::OPC_ST_WR:   state_q <= snv_pkg::ST_SWR;
              snv_pkg::OPC_READ:    state_q <= snv_pkg::ST_ADDR;
              snv_pkg::OPC_WRITE:   state_q <= snv_pkg::ST_ADDR;
              snv_pkg::OPC_FAST_RD: state_q <= snv_pkg::ST_ADDR;
              snv_pkg::OPC_ID_RD:   state_q <= snv_pkg::ST_IDRD;
              default:              state_q <= snv_pkg::ST_IGN;
            endcase
          end
        end
        snv_pkg::ST_ADDR:
        begin
          if (cnt_q == snv_pkg::ADDR_LAST)                            // [R16]
          begin
            cnt_q <= 5'h00;
            if (cmd_q == snv_pkg::OPC_FAST_RD)
              state_q <= snv_pkg::ST_DUMMY;                           // [R20]
            else if (cmd_q == snv_pkg::OPC_WRITE)
              state_q <= snv_pkg::ST_WDATA;
            else
              state_q <= snv_pkg::ST_RDATA;
          end
        end
        snv_pkg::ST_DUMMY:
        begin
          if (cnt_q == snv_pkg::BYTE_LAST)                            // [R20]
          begin
            cnt_q   <= 5'h00;
            state_q <= snv_pkg::ST_RDATA;
          end
        end
        snv_pkg::ST_SWR:
        begin
          if (cnt_q == snv_pkg::BYTE_LAST)
            state_q <= snv_pkg::ST_IGN;
        end
        default:
        begin
          state_q <= state_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input shifter, opcode and address
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      sh_q  <= 16'h0000;
      cmd_q <= 8'h00;
    end
    else if (sck_rise)
    begin
      sh_q <= word_in;                                                // [R01]
      if (opc_done)
        cmd_q <= byte_in;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      addr_q <= 16'h0000;
    else if (sck_rise && (state_q == snv_pkg::ST_ADDR) && (cnt_q == snv_pkg::ADDR_LAST))
      addr_q <= word_in;                                              // [R16]
    else if (sck_rise && (state_q == snv_pkg::ST_WDATA) && (cnt_q[2:0] == 3'h7))
      addr_q <= addr_q + 16'h0001;                                    // [R19]
    else if (sck_fall && (state_q == snv_pkg::ST_RDATA) && (oc_q[2:0] == 3'h7))
      addr_q <= addr_q + 16'h0001;                                    // [R17]
  end

  snv_mem u_mem (
    .i_clk   (I_MCLK),
    .i_addr  (addr_q),
    .i_we    (mem_we),
    .i_wdata (byte_in),
    .o_rdata (mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status register and enable latch
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      stat_q <= snv_pkg::ST_RESET;
    else if (st_we)
      stat_q[7:snv_pkg::ST_NV_LO_BIT] <= byte_in[7:snv_pkg::ST_NV_LO_BIT]; // [R08] [R09]
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      wel_q <= 1'b0;                                                  // [R11]
    else if (sleep_q && waking_q && (rec_q == 16'(REC_CYCLES - 1)))
      wel_q <= 1'b0;                                                  // [R11]
    else if (opc_done && (byte_in == snv_pkg::OPC_SET_EN))
      wel_q <= 1'b1;                                                  // [R10]
    else if (opc_done && (byte_in == snv_pkg::OPC_CLR_EN))
      wel_q <= 1'b0;                                                  // [R10] [R11]
    else if (cs_rise && wcmd_q)
      wel_q <= 1'b0;                                                  // [R11]
  end

  // remembers a recognised status write or memory write until select rises
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      wcmd_q <= 1'b0;
    else if (opc_done && ((byte_in == snv_pkg::OPC_ST_WR) || (byte_in == snv_pkg::OPC_WRITE)))
      wcmd_q <= 1'b1;
    else if (cs_rise)
      wcmd_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep and recovery
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      sleep_pend_q <= 1'b0;
    else if (opc_done && (byte_in == snv_pkg::OPC_SLEEP))
      sleep_pend_q <= 1'b1;
    else if (sck_rise || cs_rise)
      sleep_pend_q <= 1'b0;                                           // [R24]
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      sleep_q  <= 1'b0;
      waking_q <= 1'b0;
      rec_q    <= 16'h0000;
    end
    else if (!sleep_q)
    begin
      sleep_q  <= cs_rise && sleep_pend_q;                            // [R24]
      waking_q <= 1'b0;
      rec_q    <= 16'h0000;
    end
    else if (waking_q)
    begin
      rec_q <= rec_q + 16'h0001;
      if (rec_q == 16'(REC_CYCLES - 1))
      begin
        sleep_q  <= 1'b0;                                             // [R24]
        waking_q <= 1'b0;
      end
    end
    else if (cs_fall)
    begin
      waking_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      oc_q <= 6'h00;
    else if (!sel)
      oc_q <= 6'h00;
    else if (sck_fall && out_state)
    begin
      if ((state_q != snv_pkg::ST_IDRD) || (oc_q != snv_pkg::ID_BITS))
        oc_q <= oc_q + 6'h01;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      so_q <= 1'b0;
    else if (sck_fall)
    begin
      case (state_q)
        snv_pkg::ST_SRD:   so_q <= status_rd[3'h7 - oc_q[2:0]];     // [R13] [R25]
        snv_pkg::ST_RDATA: so_q <= mem_rd[3'h7 - oc_q[2:0]];        // [R16] [R25]
        snv_pkg::ST_IDRD:
        begin
          if (oc_q != snv_pkg::ID_BITS)
            so_q <= snv_pkg::IDENT_VALUE[5'h1f - oc_q[4:0]];        // [R23]
        end
        default:           so_q <= so_q;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      oe_q <= 1'b0;
    else
      oe_q <= run && out_state;                                       // [R02] [R04]
  end

  assign O_SO    = so_q;
  assign O_SO_OE = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);

  a_desel_float:                                                      // [R02]
    assert property (pin_s.cs_n |=> !O_SO_OE)
    else $error("output driven while deselected");
  a_hold_float:                                                       // [R04]
    assert property (!pin_s.hold_n |=> !O_SO_OE && $stable(cnt_q))
    else $error("output or sequence active during hold");
  a_short_opcode:                                                     // [R07]
    assert property (cs_rise && $past(state_q) == snv_pkg::ST_OPC |=> $stable(wel_q))
    else $error("partial opcode changed state");
  a_set_latch:                                                        // [R10]
    assert property (opc_done && byte_in == snv_pkg::OPC_SET_EN |=> wel_q ##1 status_rd[1])
    else $error("enable latch not set");
  a_clear_on_end:                                                     // [R11]
    assert property (cs_rise && wcmd_q |=> !wel_q)
    else $error("enable latch kept after write command");
  a_mem_gate:                                                         // [R12]
    assert property (mem_we |-> wel_q && !prot_hit(stat_q[3:2], addr_q))
    else $error("array write while locked or protected");
  a_status_gate:                                                      // [R22]
    assert property (st_we |-> wel_q && (!stat_q[7] || pin_s.wp_n) ##1 !stat_q[0] && !stat_q[1])
    else $error("status write ungated");
  a_read_wrap:                                                        // [R17]
    assert property (sck_fall && state_q == snv_pkg::ST_RDATA && oc_q[2:0] == 3'h7
                     && addr_q == snv_pkg::ADDR_TOP |=> addr_q == 16'h0000)
    else $error("read address did not wrap");
  a_sleep_entry:                                                      // [R24]
    assert property ($rose(sleep_q) |-> $past(sleep_pend_q) && $past(cs_rise))
    else $error("sleep entered without pending opcode");
  a_id_hold:                                                          // [R23]
    assert property (state_q == snv_pkg::ST_IDRD && oc_q == snv_pkg::ID_BITS && sel
                     |=> $stable(O_SO))
    else $error("ident output moved after last bit");

  c_status_read: cover property (state_q == snv_pkg::ST_SRD && sck_fall);
  c_mem_write:   cover property (mem_we);
  c_fast_read:   cover property (state_q == snv_pkg::ST_DUMMY ##[1:200] state_q == snv_pkg::ST_RDATA);
  c_sleep_wake:  cover property (sleep_q ##[1:1000] !sleep_q);

endmodule : snv_top

// ===== snv_pkg.sv
package snv_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned MCLK_MHZ    = 100;
  localparam int unsigned REC_TIME_US = 400;
  // longest time; whole microseconds times whole MHz, so the cycle count is exact
  localparam int unsigned REC_CYCLES  = REC_TIME_US * MCLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // opcodes
  localparam logic [7:0] OPC_SET_EN  = 8'h06;
  localparam logic [7:0] OPC_CLR_EN  = 8'h04;
  localparam logic [7:0] OPC_ST_RD   = 8'h05;
  localparam logic [7:0] OPC_ST_WR   = 8'h01;
  localparam logic [7:0] OPC_READ    = 8'h03;
  localparam logic [7:0] OPC_WRITE   = 8'h02;
  localparam logic [7:0] OPC_ID_RD   = 8'h9f;
  localparam logic [7:0] OPC_FAST_RD = 8'h0b;
  localparam logic [7:0] OPC_SLEEP   = 8'hb9;

  ////////////////////////////////////////////////////////////////////////////
  // protection_status layout
  localparam int unsigned ST_PROT_EN_BIT = 7;
  localparam int unsigned ST_NV_LO_BIT   = 2;
  localparam int unsigned ST_BP_HI_BIT   = 3;
  localparam int unsigned ST_BP_LO_BIT   = 2;
  localparam logic [7:0]  ST_RESET       = 8'h00;
  localparam logic [1:0]  BP_NONE        = 2'h0;
  localparam logic [1:0]  BP_QUARTER     = 2'h1;
  localparam logic [1:0]  BP_HALF        = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // array and sequencing
  localparam int unsigned ADDR_W         = 16;
  localparam logic [15:0] PROT_QTR_BASE  = 16'hc000;
  localparam logic [15:0] PROT_HALF_BASE = 16'h8000;
  localparam logic [15:0] ADDR_TOP       = 16'hffff;
  localparam logic [4:0]  BYTE_LAST      = 5'h07;
  localparam logic [4:0]  ADDR_LAST      = 5'h0f;
  localparam logic [5:0]  ID_BITS        = 6'h20;
  // arbitrary identification value
  localparam logic [31:0] IDENT_VALUE    = 32'h5a3c_0f81;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } snv_pins_t;

  localparam snv_pins_t PINS_IDLE = 5'h1b;

  typedef enum logic [3:0] {
    ST_OPC,
    ST_ADDR,
    ST_DUMMY,
    ST_RDATA,
    ST_WDATA,
    ST_SRD,
    ST_SWR,
    ST_IDRD,
    ST_IGN
  } snv_state_t;

endpackage : snv_pkg

// ===== snv_sync.sv
`timescale 1ns/1ns
module snv_sync #(
  parameter int unsigned  W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_q <= RST;
      o_q    <= RST;
    end
    else
    begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end

endmodule : snv_sync

// ===== snv_mem.sv
`timescale 1ns/1ns
module snv_mem (
  // clock
  input  wire logic        i_clk,
  // access
  input  wire logic [15:0] i_addr,
  input  wire logic        i_we,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata
);

  logic [7:0] mem [0:(1 << snv_pkg::ADDR_W) - 1];

  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end

endmodule : snv_mem

// ===== snv_host.sv
`timescale 1ns/1ns
module snv_host (
  // clock
  input  wire logic i_mclk,
  // serial link
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si,
  output logic      o_hold_n,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  logic mode3;
  logic so_last;
  logic so_line;
  logic oe_seen;
  logic cs_d;

  // a released output shows the inverse of its last level
  assign so_line = i_so_oe ? i_so : ~so_last;

  // a select fall restarts the record of a driven output
  always @(posedge i_mclk)
  begin
    cs_d <= o_cs_n;
    if (i_so_oe)
      so_last <= i_so;
    if (cs_d && !o_cs_n)
      oe_seen <= i_so_oe;
    else if (!o_cs_n && i_so_oe)
      oe_seen <= 1'b1;
  end

  initial
  begin
    o_cs_n   = 1'b1;
    o_sck    = 1'b0;
    o_hold_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tick

  // idle level of the serial clock picks mode 0 or mode 3
  task automatic start(input logic m3);
    mode3 = m3;
    o_sck = m3;
    tick(2);
    o_cs_n  = 1'b0;
    tick(4);
  endtask : start

  // data set at the fall, taken at the rise, output read mid-high
  task automatic shift(input logic b, output logic r);
    o_sck = 1'b0;
    o_si  = b;
    tick(4);
    o_sck = 1'b1;
    tick(2);
    r = so_line;
    tick(2);
  endtask : shift

  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
      shift(tx[i], rx[i]);
  endtask : xbyte

  task automatic stop();
    o_sck = mode3;
    tick(4);
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    tick(6);
  endtask : stop

  // hold entered and left with the serial clock high
  task automatic pause(output logic oe_h);
    logic r;
    o_hold_n = 1'b0;
    tick(6);
    oe_h = i_so_oe;
    shift(1'b1, r);
    shift(1'b0, r);
    o_hold_n = 1'b1;
    tick(4);
  endtask : pause
endmodule : snv_host

// ===== snv_top_bench.sv
`timescale 1ns/1ns
module snv_top_bench;
  localparam int unsigned REC = 50;

  logic        mclk = 1'b0;
  logic        rst_n;
  logic        wp_n;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        hold_n;
  logic        so;
  logic        so_oe;
  logic        oe_h;
  logic [7:0]  rx;
  logic [7:0]  v0;
  logic [7:0]  v1;
  logic [31:0] id;
  int          num_errors = 0;
  int          tests_run = 0;

  always #5 mclk = ~mclk;

  snv_top #(.REC_CYCLES(REC)) u_dut (
    .I_MCLK   (mclk),
    .I_RST_N  (rst_n),
    .I_CS_N   (cs_n),
    .I_SCK    (sck),
    .I_SI     (si),
    .O_SO     (so),
    .O_SO_OE  (so_oe),
    .I_HOLD_N (hold_n),
    .I_WP_N   (wp_n)
  );

  snv_host u_host (
    .i_mclk   (mclk),
    .o_cs_n   (cs_n),
    .o_sck    (sck),
    .o_si     (si),
    .o_hold_n (hold_n),
    .i_so     (so),
    .i_so_oe  (so_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic fin();
    u_host.stop();
    check("oe after deselect", so_oe, 1'b0);
  endtask : fin

  task automatic cmd(input logic [7:0] opc);
    u_host.start(1'b0);
    u_host.xbyte(opc, rx);
    fin();
  endtask : cmd

  task automatic st_write(input logic [7:0] v);
    cmd(snv_pkg::OPC_SET_EN);
    u_host.start(1'b0);
    u_host.xbyte(snv_pkg::OPC_ST_WR, rx);
    u_host.xbyte(v, rx);
    fin();
  endtask : st_write

  task automatic st_chk(input string what, input logic [7:0] exp);
    u_host.start(1'b0);
    u_host.xbyte(snv_pkg::OPC_ST_RD, rx);
    u_host.xbyte(8'ha5, v0);
    u_host.xbyte(8'h5a, v1);
    fin();
    check(what, v0, exp);
    check(what, v1, exp);
  endtask : st_chk

  task automatic head(input logic m3, input logic [7:0] opc, input logic [15:0] a);
    u_host.start(m3);
    u_host.xbyte(opc, rx);
    u_host.xbyte(a[15:8], rx);
    u_host.xbyte(a[7:0], rx);
  endtask : head

  task automatic mem_write(input logic en, input logic [15:0] a, input logic [7:0] d0,
                           input logic [7:0] d1);
    if (en)
      cmd(snv_pkg::OPC_SET_EN);
    head(1'b0, snv_pkg::OPC_WRITE, a);
    u_host.xbyte(d0, rx);
    u_host.xbyte(d1, rx);
    fin();
  endtask : mem_write

  task automatic mem_read(input logic m3, input logic [7:0] opc, input logic [15:0] a);
    head(m3, opc, a);
    if (opc == snv_pkg::OPC_FAST_RD)
      u_host.xbyte(8'hff, rx);
    u_host.xbyte(8'h5a, v0);
    u_host.xbyte(8'ha5, v1);
    fin();
  endtask : mem_read

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    rst_n = 1'b0;
    wp_n  = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    u_host.tick(4);
    st_chk("status after reset", 8'h00);
    cmd(snv_pkg::OPC_SET_EN);
    st_chk("latch set", 8'h02);
    cmd(snv_pkg::OPC_CLR_EN);
    st_chk("latch cleared", 8'h00);
    $display("latch test done");
    u_host.start(1'b0);
    for (int i = 7; i >= 3; i--)
      u_host.shift(snv_pkg::OPC_SET_EN[i], oe_h);
    fin();
    for (int i = 7; i >= 0; i--)
      u_host.shift(snv_pkg::OPC_SET_EN[i], oe_h);
    st_chk("short or deselected opcode", 8'h00);
    $display("ignored opcode test done");
    mem_write(1'b1, 16'h0010, 8'h3c, 8'hc3);
    st_chk("latch after write", 8'h00);
    mem_write(1'b0, 16'h0010, 8'h55, 8'haa);
    mem_read(1'b0, snv_pkg::OPC_READ, 16'h0010);
    check("read byte 0", v0, 8'h3c);
    check("read byte 1", v1, 8'hc3);
    mem_write(1'b1, 16'hffff, 8'h77, 8'h88);
    mem_read(1'b0, snv_pkg::OPC_READ, 16'hffff);
    check("wrap byte 0", v0, 8'h77);
    check("wrap byte 1", v1, 8'h88);
    mem_read(1'b1, snv_pkg::OPC_FAST_RD, 16'h0010);
    check("fast byte 0", v0, 8'h3c);
    check("fast byte 1", v1, 8'hc3);
    $display("memory test done");
    st_write(8'hff);
    st_chk("status written", 8'hfc);
    wp_n = 1'b0;
    st_write(8'h00);
    st_chk("status guarded", 8'hfc);
    wp_n = 1'b1;
    for (int k = 1; k < 4; k++)
    begin
      st_write(8'(k << 2));
      mem_write(1'b1, 16'hffff, 8'h99, 8'(k));
      mem_read(1'b0, snv_pkg::OPC_READ, 16'hffff);
      check("protected top", v0, 8'h77);
      check("array bottom", v1, (k == 3) ? 8'h02 : 8'(k));
    end
    st_write(8'h00);
    st_chk("status restored", 8'h00);
    $display("protection test done");
    cmd(snv_pkg::OPC_SET_EN);
    u_host.start(1'b0);
    u_host.xbyte(snv_pkg::OPC_ST_RD, rx);
    u_host.xbyte(8'h00, v0);
    u_host.pause(oe_h);
    u_host.xbyte(8'h00, v1);
    fin();
    check("oe in hold", oe_h, 1'b0);
    check("status before hold", v0, 8'h02);
    check("status after hold", v1, 8'h02);
    $display("hold test done");
    u_host.start(1'b1);
    u_host.xbyte(snv_pkg::OPC_ID_RD, rx);
    for (int k = 3; k >= 0; k--)
      u_host.xbyte(8'h00, id[k*8 +: 8]);
    u_host.xbyte(8'h00, rx);
    fin();
    check("ident", id, snv_pkg::IDENT_VALUE);
    check("ident tail", rx, {8{snv_pkg::IDENT_VALUE[0]}});
    $display("ident test done");
    cmd(snv_pkg::OPC_SET_EN);
    cmd(snv_pkg::OPC_SLEEP);
    u_host.start(1'b0);
    u_host.xbyte(snv_pkg::OPC_ST_RD, rx);
    u_host.xbyte(8'h00, v0);
    fin();
    check("oe while waking", u_host.oe_seen, 1'b0);
    u_host.tick(REC);
    st_chk("status after wake", 8'h00);
    $display("sleep test done");
    give_verdict();
  end
endmodule : snv_top_bench
